// [design/fcct_pkg.sv]
// Package with constants for the four channel counter timer
package fcct_pkg;
	localparam int NUM_CH = 4;
	localparam int CH_W = 2;
	localparam int CNT_W = 8;
	localparam int PRE_W = 8;
	// Control word bit positions
	localparam int CW_IS_CTRL = 0;
	localparam int CW_SW_RESET = 1;
	localparam int CW_TC_FOLLOWS = 2;
	localparam int CW_EXT_TRIG = 3;
	localparam int CW_RISE_EDGE = 4;
	localparam int CW_DIV256 = 5;
	localparam int CW_COUNTER = 6;
	localparam int CW_INT_EN = 7;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [4:0] VEC_RST = 5'h00;
	localparam logic [7:0] CNT_RST = 8'h00;
	// Prescale terminal counts (divide minus one)
	localparam logic [PRE_W-1:0] PRE_LAST_16 = 8'h0f;
	localparam logic [PRE_W-1:0] PRE_LAST_256 = 8'hff;
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	// Bus machine-cycle states
	typedef enum logic [1:0] {BUS_IDLE, BUS_T2, BUS_T3, BUS_WAIT_END} fcct_bus_t;
	// Channel run states
	typedef enum logic [1:0] {CH_IDLE, CH_ARMED, CH_START, CH_RUN} fcct_run_t;
endpackage

// [design/fcct_channel.sv]
// One counter timer channel: control, reload constant, prescaler and down-counter
`timescale 1ns/1ps
`default_nettype none
module fcct_channel
	import fcct_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wr_stb,
	input wire logic [7:0] wr_data,
	input wire logic trig_sync,
	output logic [CNT_W-1:0] count,
	output logic zero_evt,
	output logic int_en
);
	logic [7:0] ctrl_q;
	logic [CNT_W-1:0] tc_q;
	logic [CNT_W-1:0] cnt_q;
	logic [PRE_W-1:0] pre_q;
	logic tc_next_q;
	logic have_tc_q;
	logic trig_prev_q;
	fcct_run_t run_q;
	logic is_ctrl;
	logic edge_chg;
	logic trig_edge;
	logic act_edge;
	logic pre_tick;
	logic dec;
	logic tc_wr;

	assign is_ctrl = wr_stb && !tc_next_q && wr_data[CW_IS_CTRL];
	assign tc_wr = wr_stb && tc_next_q;
	// Slope change on a running or pending channel counts as an edge
	assign edge_chg = is_ctrl && (wr_data[CW_RISE_EDGE] != ctrl_q[CW_RISE_EDGE]) && run_q != CH_IDLE;
	assign trig_edge = ctrl_q[CW_RISE_EDGE] ? (trig_sync && !trig_prev_q) : (!trig_sync && trig_prev_q);
	assign act_edge = trig_edge || edge_chg;
	assign pre_tick = pre_q == (ctrl_q[CW_DIV256] ? PRE_LAST_256 : PRE_LAST_16);
	assign dec = run_q == CH_RUN && (ctrl_q[CW_COUNTER] ? act_edge : pre_tick);
	assign count = cnt_q;
	assign int_en = ctrl_q[CW_INT_EN];

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			trig_prev_q <= 1'b0;
		end else begin
			trig_prev_q <= trig_sync;
		end
	end

	// Control register and constant sequencing
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl_q <= CTRL_RST;
			tc_next_q <= 1'b0;
			tc_q <= CNT_RST;
			have_tc_q <= 1'b0;
		end else if (is_ctrl) begin
			ctrl_q <= wr_data;
			tc_next_q <= wr_data[CW_TC_FOLLOWS];
		end else if (tc_wr) begin
			tc_q <= wr_data;
			tc_next_q <= 1'b0;
			have_tc_q <= 1'b1;
		end
	end

	// Run state
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			run_q <= CH_IDLE;
		end else if (is_ctrl && wr_data[CW_SW_RESET]) begin
			run_q <= CH_IDLE;
		end else if (tc_wr && run_q == CH_IDLE) begin
			// Counter mode runs at once; in timer mode external trigger waits for an edge, otherwise one clock of setup
			if (!wr_data[CW_IS_CTRL] && ctrl_q[CW_COUNTER]) begin
				run_q <= CH_RUN;
			end else if (ctrl_q[CW_COUNTER]) begin
				run_q <= CH_RUN;
			end else if (ctrl_q[CW_EXT_TRIG]) begin
				run_q <= CH_ARMED;
			end else begin
				run_q <= CH_START;
			end
		end else begin
			case (run_q)
				CH_ARMED: begin
					if (act_edge) begin
						run_q <= CH_RUN;
					end
				end
				CH_START: begin
					run_q <= CH_RUN;
				end
				default: begin
					run_q <= run_q;
				end
			endcase
		end
	end

	// Prescaler only runs in timer mode once started
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pre_q <= '0;
		end else if (run_q != CH_RUN || ctrl_q[CW_COUNTER] || pre_tick) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_q + 8'h01;
		end
	end

	// Down-counter, reloads with no lost cycle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_q <= CNT_RST;
			zero_evt <= 1'b0;
		end else begin
			zero_evt <= 1'b0;
			if (tc_wr && run_q == CH_IDLE) begin
				cnt_q <= wr_data;
			end else if (dec) begin
				if (cnt_q == CNT_ONE) begin
					cnt_q <= tc_q;
					zero_evt <= 1'b1;
				end else begin
					cnt_q <= cnt_q - CNT_ONE;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [design/fcct_top.sv]
// Four channel counter timer with host I/O port and vectored interrupt
`timescale 1ns/1ps
`default_nettype none
module fcct_top
	import fcct_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic CE_N,
	input wire logic RD_N,
	input wire logic IO_REQUEST_N,
	input wire logic MACHINE_CYCLE_ONE_N,
	input wire logic [fcct_pkg::CH_W-1:0] CS,
	input wire logic [7:0] D_IN,
	output logic [7:0] D_OUT,
	output logic D_OE_N,
	input wire logic [fcct_pkg::NUM_CH-1:0] COUNT_TRIGGER_INPUT,
	output logic [2:0] ZERO_COUNT_PULSE,
	output logic INT_OUT,
	output logic INT_OE_N,
	input wire logic PRIORITY_IN,
	output logic PRIORITY_OUT
);
	import fcct_pkg::*;

	logic [CH_W-1:0] cs_s1_q, cs_s2_q;
	logic [7:0] d_s1_q, d_s2_q;
	logic ce_s1_q, ce_s2_q, rd_s1_q, rd_s2_q, io_request_n_s1_q, io_request_n_s2_q, m1_s1_q, m1_s2_q, iei_s1_q, iei_s2_q;
	logic [NUM_CH-1:0] trg_s1_q, trg_s2_q;
	fcct_bus_t bus_q;
	logic [4:0] vec_q;
	logic [NUM_CH-1:0] pend_q;
	logic [NUM_CH-1:0] serv_q;
	logic [NUM_CH-1:0] wr_stb;
	logic [NUM_CH-1:0] zero_evt;
	logic [NUM_CH-1:0] int_en;
	logic [CNT_W-1:0] count [NUM_CH];
	logic io_cycle, ack_cycle, wr_take;
	logic ack_q, ack_first;
	logic ch0_tc_q;
	logic [CH_W-1:0] win_ch;
	logic any_pend;

	// Lowest numbered set bit wins
	function automatic logic [CH_W-1:0] prio_enc(input logic [NUM_CH-1:0] req);
		logic [CH_W-1:0] r;
		r = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (req[i]) begin
				r = CH_W'(i);
			end
		end
		return r;
	endfunction

	// Bus pins are asynchronous to this clock
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			cs_s1_q <= '0;
			cs_s2_q <= '0;
			d_s1_q <= '0;
			d_s2_q <= '0;
			ce_s1_q <= 1'b1;
			ce_s2_q <= 1'b1;
			rd_s1_q <= 1'b1;
			rd_s2_q <= 1'b1;
			io_request_n_s1_q <= 1'b1;
			io_request_n_s2_q <= 1'b1;
			m1_s1_q <= 1'b1;
			m1_s2_q <= 1'b1;
		end else begin
			cs_s1_q <= CS;
			cs_s2_q <= cs_s1_q;
			d_s1_q <= D_IN;
			d_s2_q <= d_s1_q;
			ce_s1_q <= CE_N;
			ce_s2_q <= ce_s1_q;
			rd_s1_q <= RD_N;
			rd_s2_q <= rd_s1_q;
			io_request_n_s1_q <= IO_REQUEST_N;
			io_request_n_s2_q <= io_request_n_s1_q;
			m1_s1_q <= MACHINE_CYCLE_ONE_N;
			m1_s2_q <= m1_s1_q;
		end
	end

	// Priority chain keeps running in reset so the output can follow it
	always_ff @(posedge CLK) begin
		iei_s1_q <= PRIORITY_IN;
		iei_s2_q <= iei_s1_q;
	end

	// Acknowledge is taken once, on its first synchronised cycle
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= ack_cycle;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			trg_s1_q <= '0;
			trg_s2_q <= '0;
		end else begin
			trg_s1_q <= COUNT_TRIGGER_INPUT;
			trg_s2_q <= trg_s1_q;
		end
	end

	assign io_cycle = !ce_s2_q && !io_request_n_s2_q && m1_s2_q;
	assign ack_cycle = !m1_s2_q && !io_request_n_s2_q;
	assign ack_first = ack_cycle && !ack_q;
	assign any_pend = |pend_q;
	assign win_ch = prio_enc(pend_q);

	// Write strobe once per cycle, two clocks after the request is seen
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			bus_q <= BUS_IDLE;
		end else begin
			case (bus_q)
				BUS_IDLE: begin
					if (io_cycle && rd_s2_q) begin
						bus_q <= BUS_T2;
					end else if (io_cycle) begin
						bus_q <= BUS_WAIT_END;
					end
				end
				BUS_T2: begin
					bus_q <= BUS_T3;
				end
				BUS_T3: begin
					bus_q <= BUS_WAIT_END;
				end
				BUS_WAIT_END: begin
					if (!io_cycle) begin
						bus_q <= BUS_IDLE;
					end
				end
				default: begin
					bus_q <= BUS_IDLE;
				end
			endcase
		end
	end

	assign wr_take = bus_q == BUS_T3;

	generate
		for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
			// Vector bytes never reach a channel
			assign wr_stb[c] = wr_take && cs_s2_q == CH_W'(c) &&
				!(c == 0 && !d_s2_q[CW_IS_CTRL] && !ch0_tc_q);
			fcct_channel u_ch (
				.clk(CLK),
				.rst_b(RST_B),
				.wr_stb(wr_stb[c]),
				.wr_data(d_s2_q),
				.trig_sync(trg_s2_q[c]),
				.count(count[c]),
				.zero_evt(zero_evt[c]),
				.int_en(int_en[c])
			);
		end
	endgenerate

	// Vector only when channel 0 is not expecting a constant
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			ch0_tc_q <= 1'b0;
		end else if (wr_take && cs_s2_q == '0) begin
			ch0_tc_q <= !ch0_tc_q && d_s2_q[CW_IS_CTRL] && d_s2_q[CW_TC_FOLLOWS];
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			vec_q <= VEC_RST;
		end else if (wr_take && cs_s2_q == '0 && !ch0_tc_q && !d_s2_q[CW_IS_CTRL]) begin
			vec_q <= d_s2_q[7:3];
		end
	end

	// Pending requests; a new zero count wins over acknowledge clearing
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			pend_q <= '0;
			serv_q <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (zero_evt[i] && int_en[i]) begin
					pend_q[i] <= 1'b1;
				end else if (!int_en[i] || (ack_first && iei_s2_q && any_pend && win_ch == CH_W'(i))) begin
					pend_q[i] <= 1'b0;
				end
			end
			if (ack_first && iei_s2_q && any_pend) begin
				serv_q[win_ch] <= 1'b1;
			end else if (!iei_s2_q) begin
				serv_q <= '0;
			end
		end
	end

	// Data bus: read count, or vector on acknowledge
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			D_OUT <= 8'h00;
			D_OE_N <= 1'b1;
		end else if (io_cycle && !rd_s2_q) begin
			D_OUT <= count[cs_s2_q];
			D_OE_N <= 1'b0;
		end else if (ack_first && iei_s2_q && any_pend) begin
			D_OUT <= {vec_q, win_ch, 1'b0};
			D_OE_N <= 1'b0;
		end else if (!ack_cycle) begin
			D_OUT <= 8'h00;
			D_OE_N <= 1'b1;
		end
	end

	// Outputs registered; channel 3 has no pin
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			ZERO_COUNT_PULSE <= '0;
			INT_OE_N <= 1'b1;
			PRIORITY_OUT <= iei_s2_q;
		end else begin
			ZERO_COUNT_PULSE <= zero_evt[2:0];
			INT_OE_N <= !any_pend;
			PRIORITY_OUT <= iei_s2_q && !(|serv_q) && !any_pend;
		end
	end

	always_ff @(posedge CLK) begin
		INT_OUT <= 1'b0;
	end
endmodule
`default_nettype wire

// [test/fcct_checker.sv]
// Port checker for the four channel counter timer
`timescale 1ns/1ps
`default_nettype none
module fcct_checker
	import fcct_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic CE_N,
	input wire logic RD_N,
	input wire logic IO_REQUEST_N,
	input wire logic MACHINE_CYCLE_ONE_N,
	input wire logic [fcct_pkg::CH_W-1:0] CS,
	input wire logic [7:0] D_IN,
	input wire logic [7:0] D_OUT,
	input wire logic D_OE_N,
	input wire logic [fcct_pkg::NUM_CH-1:0] COUNT_TRIGGER_INPUT,
	input wire logic [2:0] ZERO_COUNT_PULSE,
	input wire logic INT_OUT,
	input wire logic INT_OE_N,
	input wire logic PRIORITY_IN,
	input wire logic PRIORITY_OUT
);
	default clocking @(posedge CLK); endclocking
	// Reset checks run without disable, else they could never fire
	property p_rst_idle;
		!RST_B |=> D_OE_N && INT_OE_N && ZERO_COUNT_PULSE == 3'h0;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("outputs active after reset");
	property p_rst_prio;
		(!RST_B && $stable(PRIORITY_IN))[*4] |-> PRIORITY_OUT == PRIORITY_IN;
	endproperty
	a_rst_prio: assert property (p_rst_prio) else $error("priority out not following in reset");
	property p_zc_pulse;
		disable iff (!RST_B) ZERO_COUNT_PULSE != 3'h0 |=> (ZERO_COUNT_PULSE & $past(ZERO_COUNT_PULSE)) == 3'h0;
	endproperty
	a_zc_pulse: assert property (p_zc_pulse) else $error("zero count output longer than a pulse");
	property p_prio_block;
		disable iff (!RST_B) !PRIORITY_IN[*4] |-> !PRIORITY_OUT;
	endproperty
	a_prio_block: assert property (p_prio_block) else $error("priority out high with priority in low");
	property p_bus_float;
		disable iff (!RST_B) IO_REQUEST_N[*5] |-> D_OE_N;
	endproperty
	a_bus_float: assert property (p_bus_float) else $error("data bus driven without request");
	property p_drive_late;
		disable iff (!RST_B) $fell(D_OE_N) |-> !$past(IO_REQUEST_N, 2);
	endproperty
	a_drive_late: assert property (p_drive_late) else $error("data bus driven too early");
	property p_read_stands;
		disable iff (!RST_B) !D_OE_N && !IO_REQUEST_N |=> !D_OE_N;
	endproperty
	a_read_stands: assert property (p_read_stands) else $error("read data dropped during request");
	property p_no_prio_ack;
		disable iff (!RST_B) (!PRIORITY_IN && !MACHINE_CYCLE_ONE_N && !IO_REQUEST_N)[*5] |-> D_OE_N;
	endproperty
	a_no_prio_ack: assert property (p_no_prio_ack) else $error("vector driven without priority");
	property p_vec_lsb;
		disable iff (!RST_B) !D_OE_N && !MACHINE_CYCLE_ONE_N && !$past(MACHINE_CYCLE_ONE_N, 3) |-> !D_OUT[0];
	endproperty
	a_vec_lsb: assert property (p_vec_lsb) else $error("vector low bit set");
endmodule
bind fcct_top fcct_checker u_chk (.CLK, .RST_B, .CE_N, .RD_N, .IO_REQUEST_N, .MACHINE_CYCLE_ONE_N, .CS, .D_IN,
	.D_OUT, .D_OE_N, .COUNT_TRIGGER_INPUT, .ZERO_COUNT_PULSE, .INT_OUT, .INT_OE_N, .PRIORITY_IN, .PRIORITY_OUT);
`default_nettype wire

// [test/fcct_host.sv]
// Host processor model on the eight bit I/O port
`timescale 1ns/1ps
`default_nettype none
module fcct_host (
	input wire logic clk,
	input wire logic [7:0] d_out,
	input wire logic d_oe_n,
	output logic ce_n,
	output logic rd_n,
	output logic io_request_n_n,
	output logic m1_n,
	output logic [1:0] cs,
	output logic [7:0] d_in
);
	initial begin
		ce_n = 1'b1;
		rd_n = 1'b1;
		io_request_n_n = 1'b1;
		m1_n = 1'b1;
		cs = 2'h0;
		d_in = 8'h00;
	end
	// Held five clocks: the pins pass a two flop synchroniser
	task automatic io(input logic rd, input logic ack, input logic [1:0] ch, input logic [7:0] d,
		output logic [7:0] q, output logic oe_n);
		@(posedge clk);
		#2;
		cs = ch;
		rd_n = !rd;
		m1_n = !ack;
		ce_n = ack;
		io_request_n_n = 1'b0;
		d_in = d;
		repeat (5) @(posedge clk);
		#1;
		q = d_out;
		oe_n = d_oe_n;
		#1;
		ce_n = 1'b1;
		io_request_n_n = 1'b1;
		rd_n = 1'b1;
		m1_n = 1'b1;
		d_in = ~d; // Released bus must not keep the old byte
		repeat (4) @(posedge clk);
		#2;
	endtask
	task automatic prog(input logic [1:0] ch, input logic [7:0] cw, input logic [7:0] tc);
		logic [7:0] q;
		logic oe;
		io(1'b0, 1'b0, ch, cw, q, oe);
		io(1'b0, 1'b0, ch, tc, q, oe);
	endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the four channel counter timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import fcct_pkg::*;
	typedef struct {logic [1:0] ch; logic [7:0] cw; logic [7:0] tc; int n; logic [7:0] cnt; int zc;} fcct_row_t;
	logic CLK = 1'b0;
	logic RST_B = 1'b0;
	logic CE_N, RD_N, IO_REQUEST_N, MACHINE_CYCLE_ONE_N, D_OE_N, INT_OUT, INT_OE_N, PRIORITY_OUT, oe;
	logic PRIORITY_IN = 1'b1;
	logic [1:0] CS;
	logic [7:0] D_IN, D_OUT, q;
	logic [3:0] COUNT_TRIGGER_INPUT = 4'h0;
	logic [2:0] ZERO_COUNT_PULSE;
	int err_total = 0;
	int tests_run = 0;
	int zc_n [3] = '{0, 0, 0};
	int cyc = 0;
	int t0, t1, s;
	fcct_row_t rows [4] = '{
		'{2'h0, 8'h55, 8'h05, 2, 8'h03, 0},
		'{2'h1, 8'h55, 8'h00, 1, 8'hff, 0},
		'{2'h2, 8'h55, 8'h03, 3, 8'h03, 1},
		'{2'h3, 8'h45, 8'h04, 1, 8'h03, 0}
	};
	always #12.5 CLK = ~CLK;
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		zc_n[0] <= zc_n[0] + int'(ZERO_COUNT_PULSE[0]);
		zc_n[1] <= zc_n[1] + int'(ZERO_COUNT_PULSE[1]);
		zc_n[2] <= zc_n[2] + int'(ZERO_COUNT_PULSE[2]);
	end
	fcct_top DUT (.CLK, .RST_B, .CE_N, .RD_N, .IO_REQUEST_N, .MACHINE_CYCLE_ONE_N, .CS, .D_IN, .D_OUT, .D_OE_N,
		.COUNT_TRIGGER_INPUT, .ZERO_COUNT_PULSE, .INT_OUT, .INT_OE_N, .PRIORITY_IN, .PRIORITY_OUT);
	fcct_host host (.clk(CLK), .d_out(D_OUT), .d_oe_n(D_OE_N), .ce_n(CE_N), .rd_n(RD_N), .io_request_n_n(IO_REQUEST_N),
		.m1_n(MACHINE_CYCLE_ONE_N), .cs(CS), .d_in(D_IN));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] v);
		tests_run++;
		if (v !== e) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", n, e, v);
		end
	endtask
	// Trigger period of six clocks, well above the two clock minimum
	task automatic pulse(input logic [3:0] m, input int n);
		repeat (n) begin
			COUNT_TRIGGER_INPUT = m;
			repeat (3) @(posedge CLK);
			#2;
			COUNT_TRIGGER_INPUT = 4'h0;
			repeat (3) @(posedge CLK);
			#2;
		end
		repeat (6) @(posedge CLK);
		#2;
	endtask
	task automatic wzc(output int t);
		int k;
		k = 0;
		while (ZERO_COUNT_PULSE[0] !== 1'b1 && k < 9000) begin
			@(posedge CLK);
			#1;
			k++;
		end
		t = cyc;
		@(posedge CLK);
		#2;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		#(25 * 30000);
		err_total++;
		tally_and_finish();
	end
	initial begin
		repeat (16) @(posedge CLK);
		#2;
		RST_B = 1'b1;
		repeat (4) @(posedge CLK);
		#2;
		foreach (rows[i]) begin
			host.prog(rows[i].ch, rows[i].cw, rows[i].tc);
			pulse(4'h1 << rows[i].ch, rows[i].n);
			host.io(1'b1, 1'b0, rows[i].ch, 8'h00, q, oe);
			chk("count", rows[i].cnt, q);
			if (rows[i].ch < 2'h3) chk("zc", 16'(rows[i].zc), 16'(zc_n[rows[i].ch]));
			$display("row %0d done", i);
		end
		host.prog(2'h1, 8'h55, 8'h02);
		pulse(4'h2, 1);
		host.io(1'b1, 1'b0, 2'h1, 8'h00, q, oe);
		chk("no early reload", 8'hfe, q);
		host.io(1'b0, 1'b0, 2'h0, 8'hee, q, oe);
		host.prog(2'h2, 8'hd7, 8'h01);
		host.prog(2'h3, 8'hc7, 8'h01);
		pulse(4'hc, 1);
		chk("int req", 16'h0000, 16'(INT_OE_N));
		host.io(1'b0, 1'b1, 2'h0, 8'h00, q, oe);
		chk("vec ch2", 8'hec, q);
		PRIORITY_IN = 1'b0;
		host.io(1'b0, 1'b1, 2'h0, 8'h00, q, oe);
		chk("no vec", 16'h0001, 16'(oe));
		PRIORITY_IN = 1'b1;
		host.io(1'b0, 1'b1, 2'h0, 8'h00, q, oe);
		chk("vec ch3", 8'hee, q);
		chk("int idle", 16'h0001, 16'(INT_OE_N));
		$display("interrupt test done");
		host.prog(2'h0, 8'h17, 8'h02);
		wzc(t0);
		wzc(t1);
		chk("period 16", 16'd32, 16'(t1 - t0));
		host.io(1'b0, 1'b0, 2'h0, 8'h31, q, oe);
		wzc(t0);
		wzc(t0);
		wzc(t1);
		chk("period 256", 16'd512, 16'(t1 - t0));
		host.io(1'b0, 1'b0, 2'h0, 8'h13, q, oe);
		s = zc_n[0];
		repeat (1200) @(posedge CLK);
		#2;
		chk("sw stop", 16'(s), 16'(zc_n[0]));
		host.prog(2'h0, 8'h1d, 8'h01);
		repeat (100) @(posedge CLK);
		#2;
		chk("trig wait", 16'(s), 16'(zc_n[0]));
		pulse(4'h1, 1);
		repeat (40) @(posedge CLK);
		#2;
		chk("trig start", 16'h0001, 16'(zc_n[0] > s));
		$display("timer tests done");
		RST_B = 1'b0;
		repeat (4) @(posedge CLK);
		#2;
		RST_B = 1'b1;
		s = zc_n[0];
		repeat (100) @(posedge CLK);
		#2;
		chk("hw stop", 16'(s), 16'(zc_n[0]));
		chk("bus float", 16'h0001, 16'(D_OE_N));
		chk("prio out", 16'h0001, 16'(PRIORITY_OUT));
		chk("int pin", 16'h0000, 16'(INT_OUT));
		$display("reset test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
